// >>> verilog/value_exchange.sv
/*
 * Dedicated I/O value exchange: decodes the sequencer's dedicated
 * inputs, answers numeric value requests and reflects status.
 * Assumes pins are asynchronous to pclk and an APB master on pclk.
 */
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module value_exchange
	import value_exchange_pkg::*;
#(
	parameter int IO_W = 16,
	parameter int IN_FIRST = 0,
	parameter int IN_LAST = 15,
	parameter int OUT_FIRST = 0,
	parameter int OUT_LAST = 15,
	parameter int ZONE_FIRST = 0,
	parameter int ZONE_LAST = 7
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// numeric value exchange
	input wire logic [IO_W-1:0] numeric_value_field,
	input wire logic program_select_strobe,
	input wire logic override_select_strobe,
	input wire logic program_number_request,
	input wire logic line_number_request,
	input wire logic override_value_request,
	input wire logic error_code_request,
	output logic [IO_W-1:0] numeric_value_out,
	output logic [3:0] value_present,
	// external jog
	input wire logic external_jog_enable,
	input wire logic [1:0] jog_mode_select,
	input wire logic [AXES-1:0] jog_plus_request,
	input wire logic [AXES-1:0] jog_minus_request,
	output logic jog_enabled,
	output logic [1:0] jog_mode_active,
	output logic [AXES-1:0] jog_plus_motion,
	output logic [AXES-1:0] jog_minus_motion,
	// hand and fault status
	input wire logic [MECH_COUNT*MECH_BITS-1:0] hand_inputs,
	input wire logic [MECH_COUNT-1:0] hand_fault,
	input wire logic [MECH_COUNT-1:0] pneumatic_fault,
	output logic [MECH_COUNT*MECH_BITS-1:0] hand_output_mirror,
	output logic [MECH_COUNT*MECH_BITS-1:0] hand_input_mirror,
	output logic [MECH_COUNT-1:0] hand_fault_active,
	output logic [MECH_COUNT-1:0] pneumatic_fault_active,
	output logic [MECH_COUNT-1:0] part_replacement_warning,
	// user zones
	output logic [ZONES-1:0] zone_occupancy_outputs
);
	localparam int IN_W = IN_LAST - IN_FIRST + 1;
	localparam int OUT_W = OUT_LAST - OUT_FIRST + 1;
	localparam int HW = MECH_COUNT * MECH_BITS;

	// ***************************************
	// state
	// ***************************************
	typedef struct packed {
		logic [IO_W-1:0] io;
		logic [6:0] edg;
		logic [1:0] jmode;
		logic [AXES-1:0] jplus;
		logic [AXES-1:0] jminus;
		logic [HW-1:0] hin;
		logic [MECH_COUNT-1:0] hfault;
		logic [MECH_COUNT-1:0] pfault;
	} pins_t;

	typedef struct packed {
		pins_t meta;
		pins_t sync;
		logic [6:0] prev;
		logic [31:0] program_q;
		logic [31:0] override_q;
		logic [31:0] line_q;
		logic [31:0] error_q;
		logic [3:0] pending;
		logic [3:0] present;
		logic [IO_W-1:0] io_out;
		logic jog_on;
		logic [1:0] jmode;
		logic [AXES-1:0] jplus;
		logic [AXES-1:0] jminus;
		logic [HW-1:0] hand_out;
		logic [HW-1:0] hin;
		logic [MECH_COUNT-1:0] hfault;
		logic [MECH_COUNT-1:0] pfault;
		logic [HW-1:0] maint_count;
		logic [HW-1:0] maint_limit;
		logic [MECH_COUNT-1:0] warn;
		logic [15:0] position;
		logic [31:0] rdata;
		logic ready;
		logic err;
	} state_t;

	state_t q, d;
	pins_t pins_now;
	logic [6:0] rise;
	logic [3:0] pend;
	logic [3:0] pick;
	logic setup;
	logic wr;
	zone_if zb ();

	// ***************************************
	// helpers
	// ***************************************
	function automatic logic [31:0] take_in(input logic [IO_W-1:0] v);
		logic [31:0] m;
		m = (32'h1 << IN_W) - 32'h1;
		take_in = 32'(v >> IN_FIRST) & m;
	endfunction

	function automatic logic [IO_W-1:0] put_out(input logic [31:0] v);
		logic [31:0] m;
		m = (32'h1 << OUT_W) - 32'h1;
		put_out = IO_W'((v & m) << OUT_FIRST);
	endfunction

	function automatic logic [31:0] take_out(input logic [IO_W-1:0] v);
		logic [31:0] m;
		m = (32'h1 << OUT_W) - 32'h1;
		take_out = 32'(v >> OUT_FIRST) & m;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= OFF_POSITION && a[1:0] == 2'h0) ||
			(a >= OFF_ZONE0 && a <= OFF_HAND_IN && a[1:0] == 2'h0);
	endfunction

	// ***************************************
	// next state
	// ***************************************
	always_comb begin
		pins_now = '{numeric_value_field,
			{program_select_strobe, override_select_strobe, external_jog_enable,
			error_code_request, override_value_request, line_number_request,
			program_number_request},
			jog_mode_select, jog_plus_request, jog_minus_request, hand_inputs,
			hand_fault, pneumatic_fault};
		d = q;
		d.meta = pins_now;
		d.sync = q.meta;
		d.prev = q.sync.edg;
		rise = q.sync.edg & ~q.prev;
		setup = psel & ~penable;
		wr = psel & penable & q.ready & pwrite;

		if (rise[EDG_PRG_SEL]) begin
			d.program_q = take_in(q.sync.io);
		end
		if (rise[EDG_OVR_SEL]) begin
			d.override_q = take_in(q.sync.io);
		end

		// requests queue up and are served lowest index first
		pend = q.pending | rise[3:0];
		pick = 4'(pend & (~pend + 4'h1));
		d.pending = pend & ~pick;
		if (pick != NO_SOURCE) begin
			d.present = pick;
			if (pick[EDG_REQ_PROG]) begin
				d.io_out = put_out(q.program_q);
			end else if (pick[EDG_REQ_LINE]) begin
				d.io_out = put_out(q.line_q);
			end else if (pick[EDG_REQ_OVR]) begin
				d.io_out = put_out(q.override_q);
			end else begin
				d.io_out = put_out(q.error_q);
			end
		end

		// jog enable holds until software clears it; a new edge wins
		if (rise[EDG_JOG]) begin
			d.jog_on = 1'b1;
		end else if (wr && paddr == OFF_CTRL && pwdata[CTRL_JOG_CLEAR]) begin
			d.jog_on = 1'b0;
		end
		d.jmode = q.sync.jmode;
		d.jplus = q.sync.jplus & {AXES{q.jog_on}};
		d.jminus = q.sync.jminus & {AXES{q.jog_on}};

		d.hin = q.sync.hin;
		d.hfault = q.sync.hfault;
		d.pfault = q.sync.pfault;
		for (int i = 0; i < MECH_COUNT; i++) begin
			d.warn[i] = (q.maint_limit[i*MECH_BITS +: MECH_BITS] != 8'h00) &&
				(q.maint_count[i*MECH_BITS +: MECH_BITS] >=
				q.maint_limit[i*MECH_BITS +: MECH_BITS]);
		end

		// apb: decode in setup, answer in the access cycle
		d.ready = setup;
		d.err = setup & ~mapped(paddr);
		d.rdata = RESET_WORD;
		if (setup && !pwrite) begin
			if (paddr == OFF_CTRL) begin
				d.rdata = {31'h0, q.jog_on};
			end else if (paddr == OFF_LINE) begin
				d.rdata = q.line_q;
			end else if (paddr == OFF_ERROR) begin
				d.rdata = q.error_q;
			end else if (paddr == OFF_HAND_OUT) begin
				d.rdata = 32'(q.hand_out);
			end else if (paddr == OFF_MAINT_COUNT) begin
				d.rdata = 32'(q.maint_count);
			end else if (paddr == OFF_MAINT_LIMIT) begin
				d.rdata = 32'(q.maint_limit);
			end else if (paddr == OFF_POSITION) begin
				d.rdata = {16'h0, q.position};
			end else if (paddr == OFF_STATUS) begin
				d.rdata = {8'h0, zb.occupancy, q.warn, q.pfault, q.hfault, q.jmode,
					q.jog_on, q.present};
			end else if (paddr == OFF_VALUES) begin
				d.rdata = {q.override_q[15:0], q.program_q[15:0]};
			end else if (paddr == OFF_HAND_IN) begin
				d.rdata = 32'(q.hin);
			end
		end
		if (wr) begin
			if (paddr == OFF_LINE) begin
				d.line_q = pwdata;
			end else if (paddr == OFF_ERROR) begin
				d.error_q = pwdata;
			end else if (paddr == OFF_HAND_OUT) begin
				d.hand_out = pwdata[HW-1:0];
			end else if (paddr == OFF_MAINT_COUNT) begin
				d.maint_count = pwdata[HW-1:0];
			end else if (paddr == OFF_MAINT_LIMIT) begin
				d.maint_limit = pwdata[HW-1:0];
			end else if (paddr == OFF_POSITION) begin
				d.position = pwdata[15:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ***************************************
	// zone comparator
	// ***************************************
	assign zb.position = q.position;
	assign zb.wr_en = wr && paddr >= OFF_ZONE0 && paddr <= OFF_ZONE7 && paddr[1:0] == 2'h0;
	assign zb.wr_idx = paddr[4:2];
	assign zb.wr_lo = pwdata[15:0];
	assign zb.wr_hi = pwdata[31:16];

	zone_compare #(
		.ZONE_FIRST(ZONE_FIRST),
		.ZONE_LAST(ZONE_LAST)
	) u_zone (
		.pclk(pclk),
		.presetn(presetn),
		.zb(zb)
	);

	// ***************************************
	// outputs
	// ***************************************
	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.err;
	assign numeric_value_out = q.io_out;
	assign value_present = q.present;
	assign jog_enabled = q.jog_on;
	assign jog_mode_active = q.jmode;
	assign jog_plus_motion = q.jplus;
	assign jog_minus_motion = q.jminus;
	assign hand_output_mirror = q.hand_out;
	assign hand_input_mirror = q.hin;
	assign hand_fault_active = q.hfault;
	assign pneumatic_fault_active = q.pfault;
	assign part_replacement_warning = q.warn;
	assign zone_occupancy_outputs = zb.occupancy;

	// ***************************************
	// checks
	// ***************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	prog_capture_a: assert property (
		rise[EDG_PRG_SEL] |=> q.program_q == take_in($past(q.sync.io)))
		else $error("program number not captured on select edge");
	ovr_capture_a: assert property (
		rise[EDG_OVR_SEL] |=> q.override_q == take_in($past(q.sync.io)))
		else $error("override not captured on select edge");
	one_present_a: assert property (
		$onehot0(q.present) and (q.pending != 4'h0 |=> q.present != 4'h0))
		else $error("present flags not one-hot");
	prog_serve_a: assert property (
		rise[EDG_REQ_PROG] |=> q.present[EDG_REQ_PROG] &&
		take_out(q.io_out) == take_out(put_out($past(q.program_q))))
		else $error("program request not answered");
	line_value_a: assert property (
		$rose(q.present[EDG_REQ_LINE]) |-> take_out(q.io_out) ==
		take_out(put_out($past(q.line_q))))
		else $error("line number not on output field");
	jog_enable_a: assert property (
		rise[EDG_JOG] |=> q.jog_on && jog_enabled)
		else $error("jog enable edge not taken");
	jog_hold_a: assert property (
		q.jog_on && !(wr && paddr == OFF_CTRL) |=> q.jog_on)
		else $error("jog enable dropped without clear");
	jog_gate_a: assert property (
		!q.jog_on ##1 !q.jog_on |-> q.jplus == '0 && q.jminus == '0)
		else $error("jog motion without jog enable");
	hand_fault_a: assert property (
		q.sync.hfault != '0 |=> q.hfault == $past(q.sync.hfault))
		else $error("hand fault not reflected");
	warn_a: assert property (
		q.maint_limit[7:0] != 8'h00 && q.maint_count[7:0] >= q.maint_limit[7:0]
		|=> q.warn[0])
		else $error("replacement warning missing");

	prog_req_c: cover property (rise[EDG_REQ_PROG] ##1 q.present[EDG_REQ_PROG]);
	two_req_c: cover property ($countones(pend) > 1);
	jog_c: cover property (q.jog_on && q.jplus != '0);
	apb_err_c: cover property (q.err && q.ready);
endmodule

// >>> pkg/value_exchange_pkg.sv
/*
 * Shared constants for the dedicated I/O value exchange block:
 * register map, field positions and reset values.
 * Assumes a 32-bit APB master with byte addresses.
 */
package value_exchange_pkg;
	// ***************************************
	// register byte offsets
	// ***************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_LINE = 8'h04;
	localparam logic [7:0] OFF_ERROR = 8'h08;
	localparam logic [7:0] OFF_HAND_OUT = 8'h0C;
	localparam logic [7:0] OFF_MAINT_COUNT = 8'h10;
	localparam logic [7:0] OFF_MAINT_LIMIT = 8'h14;
	localparam logic [7:0] OFF_POSITION = 8'h18;
	localparam logic [7:0] OFF_ZONE0 = 8'h20;
	localparam logic [7:0] OFF_ZONE7 = 8'h3C;
	localparam logic [7:0] OFF_STATUS = 8'h40;
	localparam logic [7:0] OFF_VALUES = 8'h44;
	localparam logic [7:0] OFF_HAND_IN = 8'h48;
	// ***************************************
	// field positions
	// ***************************************
	localparam int CTRL_JOG_CLEAR = 0;
	localparam int EDG_REQ_PROG = 0;
	localparam int EDG_REQ_LINE = 1;
	localparam int EDG_REQ_OVR = 2;
	localparam int EDG_REQ_ERR = 3;
	localparam int EDG_JOG = 4;
	localparam int EDG_OVR_SEL = 5;
	localparam int EDG_PRG_SEL = 6;
	localparam int MECH_COUNT = 3;
	localparam int MECH_BITS = 8;
	localparam int AXES = 8;
	localparam int ZONES = 8;
	// hand bit k of mechanism m is general-purpose number HAND_BASE + m*HAND_STRIDE + k
	localparam int HAND_BASE = 900;
	localparam int HAND_STRIDE = 10;
	// ***************************************
	// reset values
	// ***************************************
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
	localparam logic [3:0] NO_SOURCE = 4'h0;
endpackage

// >>> pkg/zone_if.sv
/*
 * Carrier between the register side and the zone comparator.
 * Assumes both ends run on pclk.
 */
`timescale 1ns/1ps
interface zone_if;
	logic [15:0] position;
	logic wr_en;
	logic [2:0] wr_idx;
	logic [15:0] wr_lo;
	logic [15:0] wr_hi;
	logic [7:0] occupancy;
	modport ctrl (output position, output wr_en, output wr_idx, output wr_lo, output wr_hi,
		input occupancy);
	modport zone (input position, input wr_en, input wr_idx, input wr_lo, input wr_hi,
		output occupancy);
endinterface

// >>> verilog/zone_compare.sv
/*
 * User zone comparator: holds eight position windows and flags
 * which windows contain the current position.
 * Assumes position and window writes come from logic on pclk.
 */
`timescale 1ns/1ps
module zone_compare
	import value_exchange_pkg::*;
#(
	parameter int ZONE_FIRST = 0,
	parameter int ZONE_LAST = 7
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register side
	zone_if.zone zb
);
	localparam int ZCOUNT = ZONE_LAST - ZONE_FIRST + 1;

	typedef struct packed {
		logic [ZONES-1:0] occ;
	} zstate_t;

	zstate_t q, d;
	logic [15:0] lo_q [ZONES];
	logic [15:0] hi_q [ZONES];

	always_comb begin
		d = q;
		for (int i = 0; i < ZONES; i++) begin
			d.occ[i] = (i < ZCOUNT) && (zb.position >= lo_q[i]) && (zb.position <= hi_q[i]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			for (int i = 0; i < ZONES; i++) begin
				lo_q[i] <= 16'hFFFF;
				hi_q[i] <= 16'h0000;
			end
		end else begin
			q <= d;
			if (zb.wr_en) begin
				lo_q[zb.wr_idx] <= zb.wr_lo;
				hi_q[zb.wr_idx] <= zb.wr_hi;
			end
		end
	end

	assign zb.occupancy = q.occ;
endmodule

// >>> dv/seq_model.sv
/*
 * External sequencer model: drives the dedicated input pins.
 * Assumes the block samples every pin on pclk through a synchroniser.
 */
`timescale 1ns/1ps
module seq_model (
	// clock
	input wire logic pclk,
	// dedicated pins
	output logic [15:0] field,
	output logic [6:0] strb,
	output logic [1:0] mode,
	output logic [7:0] plus,
	output logic [7:0] minus,
	output logic [23:0] hand_in,
	output logic [2:0] hfault,
	output logic [2:0] pfault
);
	initial begin
		field = 16'h0000;
		strb = 7'h00;
		mode = 2'h0;
		plus = 8'h00;
		minus = 8'h00;
		hand_in = 24'h000000;
		hfault = 3'h0;
		pfault = 3'h0;
	end
	// ***************************************
	// strobe: three cycles high, three low
	// ***************************************
	task automatic pulse(input logic [6:0] m);
		@(posedge pclk);
		strb <= m;
		repeat (3) @(posedge pclk);
		strb <= 7'h00;
		repeat (3) @(posedge pclk);
	endtask
endmodule

// >>> dv/dedicated_io_value_exchange_bench.sv
/*
 * Self-checking bench: APB driver, sequencer model and result queue.
 * Assumes the default field and zone parameters of the block.
 */
`timescale 1ns/1ps
module dedicated_io_value_exchange_bench;
	import value_exchange_pkg::*;
	typedef struct packed {logic [2:0] kind; logic [32:0] val;} note_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, jen, look;
	logic [7:0] paddr, pmot, mmot, zones, plus, minus;
	logic [31:0] pwdata, prdata, seed, p, o, l, e, r;
	logic [15:0] field, nout;
	logic [15:0] v [4];
	logic [6:0] strb;
	logic [1:0] mode, mact;
	logic [23:0] hand_in, hout, hin;
	logic [2:0] hfault, pfault, hfa, pfa, warn, look_k;
	logic [3:0] pres;
	note_t q[$];
	int fails, checks, cyc;

	value_exchange dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .numeric_value_field(field),
		.program_select_strobe(strb[6]), .override_select_strobe(strb[5]),
		.program_number_request(strb[0]), .line_number_request(strb[1]),
		.override_value_request(strb[2]), .error_code_request(strb[3]),
		.numeric_value_out(nout), .value_present(pres), .external_jog_enable(strb[4]),
		.jog_mode_select(mode), .jog_plus_request(plus), .jog_minus_request(minus),
		.jog_enabled(jen), .jog_mode_active(mact), .jog_plus_motion(pmot),
		.jog_minus_motion(mmot), .hand_inputs(hand_in), .hand_fault(hfault),
		.pneumatic_fault(pfault), .hand_output_mirror(hout), .hand_input_mirror(hin),
		.hand_fault_active(hfa), .pneumatic_fault_active(pfa),
		.part_replacement_warning(warn), .zone_occupancy_outputs(zones));
	seq_model seq (.pclk(pclk), .field(field), .strb(strb), .mode(mode), .plus(plus),
		.minus(minus), .hand_in(hand_in), .hfault(hfault), .pfault(pfault));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// ***************************************
	// result checking
	// ***************************************
	task automatic cmp(input logic [2:0] k, input logic [32:0] a);
		note_t n;
		checks++;
		if (q.size() == 0) begin
			fails++;
			$display("[FAIL] %0t unexpected result", $time);
		end else begin
			n = q.pop_front();
			if (n.kind !== k || n.val !== a) begin
				fails++;
				$display("[FAIL] %0t kind %0d got %h want %h", $time, k, a, n.val);
			end
		end
	endtask
	function automatic logic [32:0] pin_val(input logic [2:0] k);
		case (k)
			3'd1: return {13'h0000, pres, nout};
			3'd2: return {9'h000, hout};
			3'd3: return {9'h000, hin};
			3'd5: return {9'h000, zones, warn, pfa, hfa, mact, jen, pres};
			default: return {17'h00000, pmot, mmot};
		endcase
	endfunction
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) cmp(3'd0, {pslverr, prdata});
		if (look) cmp(look_k, pin_val(look_k));
		cyc++;
		if (cyc == 20000) begin
			fails++;
			$display("[FAIL] %0t timeout", $time);
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ***************************************
	// drivers
	// ***************************************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		q.push_back('{3'd0, x});
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic pin(input logic [2:0] k, input logic [32:0] x);
		q.push_back('{k, x});
		@(posedge pclk);
		look <= 1'b1;
		look_k <= k;
		@(posedge pclk);
		look <= 1'b0;
	endtask
	task automatic idle();
		repeat (6) @(posedge pclk);
	endtask
	// ***************************************
	// scenarios
	// ***************************************
	initial begin
		seed = 32'h8F0D;
		{presetn, psel, penable, pwrite, look, look_k, paddr, pwdata} = '0;
		{fails, checks, cyc} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		idle();
		rd(OFF_STATUS, 33'h0);
		rd(OFF_VALUES, 33'h0);
		rd(OFF_LINE, 33'h0);
		apb(1'b1, 8'h4C, 32'hFFFF_FFFF);
		rd(8'h4C, {1'b1, 32'h0});
		rd(8'h05, {1'b1, 32'h0});
		$display("test reset done");
		r = $random(seed) & 32'h00FF_FFFF;
		apb(1'b1, OFF_HAND_OUT, r);
		seq.hand_in <= ~r[23:0];
		seq.hfault <= 3'b101;
		seq.pfault <= 3'b010;
		idle();
		pin(3'd2, {9'h0, r[23:0]});
		pin(3'd3, {9'h0, ~r[23:0]});
		rd(OFF_STATUS, 33'h0A80);
		pin(3'd5, 33'h0A80);
		seq.hfault <= 3'b000;
		seq.pfault <= 3'b000;
		idle();
		rd(OFF_STATUS, 33'h0);
		pin(3'd5, 33'h0);
		$display("test hand done");
		r = $random(seed);
		seq.mode <= 2'b10;
		seq.plus <= r[7:0];
		seq.minus <= r[15:8];
		seq.pulse(7'h10);
		pin(3'd4, {17'h0, r[7:0], r[15:8]});
		rd(OFF_STATUS, 33'h50);
		pin(3'd5, 33'h50);
		seq.plus <= 8'h00;
		idle();
		pin(3'd4, {17'h0, 8'h00, r[15:8]});
		apb(1'b1, OFF_CTRL, 32'h1);
		seq.mode <= 2'b01;
		idle();
		pin(3'd4, 33'h0);
		rd(OFF_STATUS, 33'h20);
		pin(3'd5, 33'h20);
		$display("test jog done");
		apb(1'b1, OFF_ZONE0, 32'h0200_0100);
		apb(1'b1, OFF_ZONE7, 32'h0300_0150);
		apb(1'b1, OFF_POSITION, 32'h0150);
		rd(OFF_STATUS, 33'h0081_0020);
		pin(3'd5, 33'h0081_0020);
		apb(1'b1, OFF_POSITION, 32'h0100);
		rd(OFF_STATUS, 33'h0001_0020);
		apb(1'b1, OFF_POSITION, 32'h0300);
		rd(OFF_STATUS, 33'h0080_0020);
		apb(1'b1, OFF_POSITION, 32'h0400);
		apb(1'b1, 8'h21, 32'h0500_0400);
		rd(OFF_STATUS, 33'h20);
		rd(OFF_ZONE0, 33'h0);
		$display("test zone done");
		apb(1'b1, OFF_MAINT_LIMIT, 32'h3);
		apb(1'b1, OFF_MAINT_COUNT, 32'h2);
		rd(OFF_STATUS, 33'h20);
		apb(1'b1, OFF_MAINT_COUNT, 32'h3);
		rd(OFF_STATUS, 33'h2020);
		pin(3'd5, 33'h2020);
		apb(1'b1, OFF_MAINT_COUNT, 32'h0);
		$display("test maint done");
		p = $random(seed) & 32'hFFFF;
		o = $random(seed) & 32'hFFFF;
		l = $random(seed) & 32'hFFFF;
		e = $random(seed) & 32'hFFFF;
		v = '{p[15:0], l[15:0], o[15:0], e[15:0]};
		apb(1'b1, OFF_LINE, l);
		apb(1'b1, OFF_ERROR, e);
		seq.field <= p[15:0];
		seq.pulse(7'h40);
		seq.field <= o[15:0];
		seq.pulse(7'h20);
		seq.field <= ~o[15:0];
		idle();
		rd(OFF_VALUES, {1'b0, o[15:0], p[15:0]});
		for (int k = 0; k < 4; k++) begin
			seq.pulse(7'(1 << k));
			pin(3'd1, {13'h0, 4'(1 << k), v[k]});
		end
		seq.pulse(7'h0F);
		idle();
		pin(3'd1, {13'h0, 4'h8, v[3]});
		$display("test value exchange done");
		finish_test();
	end
endmodule
